//--- rtl/lpd_pkg.sv
// Constants, register map and timing figures for the LED PWM dimming outputs.
// Overview of operation
// - Three channels each have their own register with a 7-bit on-time code in bits 6:0 and a dimming bit in bit 7.
// - A channel's pin is driven low during the on-time of each period and is high for the rest.
// - Every PWM period lasts exactly 95 ticks of a 0.5 us time base, about 21 kHz.
// - The on-time is the code value in time-base ticks, capped at the 95-tick period, one ninety-fifth of the period (about 1.05 percent of duty) per code step.
// - With dimming clear, a newly written code is applied from the next period without any ramp.
// - With dimming set, the applied code moves one step toward the written target every 32 ms.
package lpd_pkg;

	// ------------------------------------------------------------
	// Bus and register map
	// ------------------------------------------------------------
	localparam int          LPD_ADDR_W     = 12;
	localparam int          LPD_DATA_W     = 32;
	localparam int          LPD_NUM_CH     = 3;
	localparam int          LPD_REG_W      = 8;
	localparam int          LPD_CODE_W     = 7;
	localparam int          LPD_DIM_BIT    = 7;
	localparam logic [9:0]  LPD_IDX_CH_A   = 10'h0c6;
	localparam logic [9:0]  LPD_IDX_CH_B   = 10'h0c7;
	localparam logic [9:0]  LPD_IDX_CH_C   = 10'h0c8;
	localparam logic [9:0]  LPD_IDX_STATUS = 10'h100;
	localparam logic [7:0]  LPD_REG_RST    = 8'h00;
	localparam int          LPD_STAT_LANE  = 8;
	localparam logic [1:0]  LPD_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  LPD_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          LPD_CLK_HZ     = 40_000_000;
	localparam int          LPD_TB_NS      = 500;
	localparam int          LPD_TB_CYC     = (LPD_TB_NS * (LPD_CLK_HZ / 1_000_000)) / 1000;
	localparam int          LPD_PERIOD_TICKS = 95;
	localparam int          LPD_RAMP_MS    = 32;
	localparam int          LPD_RAMP_CYC   = LPD_RAMP_MS * (LPD_CLK_HZ / 1000);
	localparam int          LPD_RAMP_W     = 21;
	localparam int          LPD_TB_W       = 5;

endpackage

//--- rtl/lpd_channel.sv
// One PWM channel: applied code, ramp stepping and the active-low pin.
`timescale 1ns/1ps
module lpd_channel
	import lpd_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  period_end,
	input  wire logic [LPD_CODE_W-1:0] tick_count,
	input  wire logic                  ramp_strobe,
	input  wire logic [LPD_CODE_W-1:0] target_code,
	input  wire logic                  ramp_enable,
	output logic                       led_n,
	output logic [LPD_CODE_W-1:0]      applied_code
);

	logic [LPD_CODE_W-1:0] duty_r;
	logic                  step_pend_r;
	logic                  led_n_r;

	// ------------------------------------------------------------
	// Ramp request
	// ------------------------------------------------------------
	// A strobe landing in the same cycle as the period end is kept, so no step is lost.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			step_pend_r <= 1'b0;
		else if (ramp_strobe)
			step_pend_r <= 1'b1;
		else if (period_end)
			step_pend_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Applied code, changed only at a period boundary
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			duty_r <= LPD_REG_RST[LPD_CODE_W-1:0];
		else if (period_end)
		begin
			if (!ramp_enable)
				duty_r <= target_code;
			else if (step_pend_r && (duty_r < target_code))
				duty_r <= duty_r + 7'h01;
			else if (step_pend_r && (duty_r > target_code))
				duty_r <= duty_r - 7'h01;
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// The count never reaches 95, so codes of 95 and above stay low all period.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			led_n_r <= 1'b1;
		else
			led_n_r <= !(tick_count < duty_r);
	end

	assign led_n        = led_n_r;
	assign applied_code = duty_r;

endmodule

//--- rtl/lpd_top.sv
// LED PWM dimming outputs: AXI4-Lite register slave, time base and three channels.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module lpd_top
	import lpd_pkg::*;
#(
	parameter int unsigned RAMP_STEP_CYCLES = LPD_RAMP_CYC
)
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [LPD_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [LPD_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [LPD_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [LPD_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic                       led_pwm_n_a,
	output logic                       led_pwm_n_b,
	output logic                       led_pwm_n_c
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                    awready_r;
	logic                    wready_r;
	logic                    bvalid_r;
	logic [1:0]              bresp_r;
	logic                    arready_r;
	logic                    rvalid_r;
	logic [1:0]              rresp_r;
	logic [LPD_DATA_W-1:0]   rdata_r;
	logic                    aw_have_r;
	logic                    w_have_r;
	logic [LPD_ADDR_W-1:0]   awaddr_r;
	logic [LPD_DATA_W-1:0]   wdata_r;
	logic [3:0]              wstrb_r;
	logic                    wr_do;
	logic [9:0]              wr_idx;
	logic [9:0]              rd_idx;
	logic [LPD_REG_W-1:0]    ch_reg_r [LPD_NUM_CH];
	logic [LPD_CODE_W-1:0]   applied   [LPD_NUM_CH];
	logic [LPD_NUM_CH-1:0]   led_n;
	logic [LPD_TB_W-1:0]     tb_cnt_r;
	logic                    tb_tick;
	logic [LPD_CODE_W-1:0]   per_cnt_r;
	logic                    period_end;
	logic [LPD_RAMP_W-1:0]   ramp_cnt_r;
	logic                    ramp_stb_r;

	localparam logic [9:0] CH_IDX [LPD_NUM_CH] = '{LPD_IDX_CH_A, LPD_IDX_CH_B, LPD_IDX_CH_C};

	// ------------------------------------------------------------
	// Write channels
	// ------------------------------------------------------------
	// Address and data are latched independently, so the master may offer them in any order.
	assign wr_do  = aw_have_r && w_have_r && !bvalid_r;
	assign wr_idx = awaddr_r[LPD_ADDR_W-1:2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b0;
			aw_have_r <= 1'b0;
			awaddr_r  <= '0;
		end
		else if (s_axi_awvalid && awready_r)
		begin
			awaddr_r  <= s_axi_awaddr;
			aw_have_r <= 1'b1;
			awready_r <= 1'b0;
		end
		else if (wr_do)
			aw_have_r <= 1'b0;
		else if (!aw_have_r && !bvalid_r)
			awready_r <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready_r <= 1'b0;
			w_have_r <= 1'b0;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end
		else if (s_axi_wvalid && wready_r)
		begin
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
			w_have_r <= 1'b1;
			wready_r <= 1'b0;
		end
		else if (wr_do)
			w_have_r <= 1'b0;
		else if (!w_have_r && !bvalid_r)
			wready_r <= 1'b1;
	end

	// Unmapped writes are answered with SLVERR and change nothing.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= LPD_RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid_r <= 1'b1;
			if ((wr_idx == LPD_IDX_CH_A) || (wr_idx == LPD_IDX_CH_B) ||
				(wr_idx == LPD_IDX_CH_C) || (wr_idx == LPD_IDX_STATUS))
				bresp_r <= LPD_RESP_OKAY;
			else
				bresp_r <= LPD_RESP_SLVERR;
		end
		else if (bvalid_r && s_axi_bready)
			bvalid_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Channel registers
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < LPD_NUM_CH; gi++)
		begin : g_reg
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					ch_reg_r[gi] <= LPD_REG_RST;
				else if (wr_do && (wr_idx == CH_IDX[gi]) && wstrb_r[0])
					ch_reg_r[gi] <= wdata_r[LPD_REG_W-1:0];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	// The status word shows the code each channel applies now, which lags the target while ramping.
	assign rd_idx = s_axi_araddr[LPD_ADDR_W-1:2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= LPD_RESP_OKAY;
			rdata_r   <= '0;
		end
		else if (s_axi_arvalid && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= LPD_RESP_OKAY;
			rdata_r   <= '0;
			if (rd_idx == LPD_IDX_CH_A)
				rdata_r[LPD_REG_W-1:0] <= ch_reg_r[0];
			else if (rd_idx == LPD_IDX_CH_B)
				rdata_r[LPD_REG_W-1:0] <= ch_reg_r[1];
			else if (rd_idx == LPD_IDX_CH_C)
				rdata_r[LPD_REG_W-1:0] <= ch_reg_r[2];
			else if (rd_idx == LPD_IDX_STATUS)
			begin
				rdata_r[LPD_CODE_W-1:0]                 <= applied[0];
				rdata_r[LPD_STAT_LANE+:LPD_CODE_W]      <= applied[1];
				rdata_r[2*LPD_STAT_LANE+:LPD_CODE_W]    <= applied[2];
			end
			else
				rresp_r <= LPD_RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_r <= 1'b0;
		else if (!rvalid_r)
			arready_r <= 1'b1;
	end

	// ------------------------------------------------------------
	// Time base and period counter
	// ------------------------------------------------------------
	assign tb_tick    = (tb_cnt_r == LPD_TB_W'(LPD_TB_CYC - 1));
	assign period_end = tb_tick && (per_cnt_r == LPD_CODE_W'(LPD_PERIOD_TICKS - 1));

	always_ff @(posedge aclk)
	begin
		if (!aresetn || tb_tick)
			tb_cnt_r <= '0;
		else
			tb_cnt_r <= tb_cnt_r + 5'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || period_end)
			per_cnt_r <= '0;
		else if (tb_tick)
			per_cnt_r <= per_cnt_r + 7'h01;
	end

	// ------------------------------------------------------------
	// Ramp step timer
	// ------------------------------------------------------------
	// Shared by all channels; it runs free, so the first step after enabling may come early.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ramp_cnt_r <= '0;
			ramp_stb_r <= 1'b0;
		end
		else if (ramp_cnt_r == LPD_RAMP_W'(RAMP_STEP_CYCLES - 1))
		begin
			ramp_cnt_r <= '0;
			ramp_stb_r <= 1'b1;
		end
		else
		begin
			ramp_cnt_r <= ramp_cnt_r + 21'h000001;
			ramp_stb_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	generate
		for (gi = 0; gi < LPD_NUM_CH; gi++)
		begin : g_ch
			lpd_channel u_ch
			(
				.aclk         (aclk),
				.aresetn      (aresetn),
				.period_end   (period_end),
				.tick_count   (per_cnt_r),
				.ramp_strobe  (ramp_stb_r),
				.target_code  (ch_reg_r[gi][LPD_CODE_W-1:0]),
				.ramp_enable  (ch_reg_r[gi][LPD_DIM_BIT]),
				.led_n        (led_n[gi]),
				.applied_code (applied[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign led_pwm_n_a   = led_n[0];
	assign led_pwm_n_b   = led_n[1];
	assign led_pwm_n_c   = led_n[2];

endmodule

//--- verif/lpd_led_load.sv
// Load model for one LED pin: counts the cycles in which the LED is lit.
`timescale 1ns/1ps
module lpd_led_load
(
	input  wire logic        aclk,
	input  wire logic        pin_n,
	input  wire logic        clr,
	output logic      [15:0] lit_cnt
);
	// The LED conducts only while the pin is pulled low.
	always_ff @(posedge aclk)
	begin
		if (clr)
			lit_cnt <= 16'h0;
		else if (!pin_n)
			lit_cnt <= lit_cnt + 16'h1;
	end
endmodule

//--- verif/lpd_monitor.sv
// Bus handshake and pin timing checks for the LED PWM block.
`timescale 1ns/1ps
module lpd_monitor
	import lpd_pkg::*;
(
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [LPD_DATA_W-1:0] s_axi_rdata,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic                  led_pwm_n_a
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// Cycles since the last falling edge of pin A
	// ------------------------------------------------------------
	logic [31:0] since_r;
	logic        seen_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			since_r <= 32'h0;
		else if ($fell(led_pwm_n_a))
			since_r <= 32'h0;
		else
			since_r <= since_r + 32'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			seen_r <= 1'b0;
		else if ($fell(led_pwm_n_a))
			seen_r <= 1'b1;
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready high right after address taken");
	a_ar_refuse: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
		else $error("arready high right after read address taken");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing wrong");
	a_b_idle_gap: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_awready && !s_axi_wready)
		else $error("readies back without idle cycle");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:23] == 9'h0)
		else $error("upper read data bits not zero");
	a_pin_period: assert property ($fell(led_pwm_n_a) && seen_r |-> since_r % 1900 == 1899)
		else $error("pin A burst not on period grid");
endmodule

bind lpd_top lpd_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .led_pwm_n_a(led_pwm_n_a));

//--- verif/tb_led_pwm_dimming_outputs.sv
// Register and pin level tests for the LED PWM block.
`timescale 1ns/1ps
`define CHK(g, e) chk((g) === (e))
module tb_led_pwm_dimming_outputs
	import lpd_pkg::*;
;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, clr;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  pin_n;
	logic [15:0] lit [3];
	logic [6:0]  cur, prv;
	int          error_cnt, n_tests, i, j, k;
	localparam logic [11:0] CH [3] = '{{LPD_IDX_CH_A, 2'b00}, {LPD_IDX_CH_B, 2'b00},
		{LPD_IDX_CH_C, 2'b00}};
	localparam logic [7:0] CODE [2][3] = '{'{8'h02, 8'h00, 8'h5f}, '{8'h01, 8'h5e, 8'h7f}};
	lpd_top #(.RAMP_STEP_CYCLES(3000)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .led_pwm_n_a(pin_n[0]), .led_pwm_n_b(pin_n[1]),
		.led_pwm_n_c(pin_n[2]));
	for (genvar g = 0; g < 3; g++)
	begin : g_load
		lpd_led_load u_load (.aclk(aclk), .pin_n(pin_n[g]), .clr(clr), .lit_cnt(lit[g]));
	end
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task chk(input bit ok);
		n_tests++;
		if (!ok)
		begin
			error_cnt++;
			$display("mismatch at %0t: value differs", $time);
		end
	endtask
	task wrap_up;
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ------------------------------------------------------------
	// AXI4-Lite master
	// ------------------------------------------------------------
	// Each task ends one edge after its release so the next call never drives a line twice.
	// A nonzero dl keeps the ready low for that many edges, so the slave must hold its answer.
	task wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s, input int dl = 0);
		awaddr <= a;
		wdata <= {24'h0, v};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (dl == 0);
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (dl == 1)
				bready <= 1'b1;
			if (dl > 0)
				dl--;
		end
		while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [11:0] a, input int dl = 0);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (dl == 0);
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (dl == 1)
				rready <= 1'b1;
			if (dl > 0)
				dl--;
		end
		while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, clr} <= 7'h0;
		{awaddr, araddr, wdata, wstrb} <= 60'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 3; i++)
		begin
			rd(CH[i]);
			`CHK({r, d}, {LPD_RESP_OKAY, 32'h0});
			wr(CH[i], 8'hd5, 4'h1);
			`CHK(r, LPD_RESP_OKAY);
			wr(CH[i], 8'h00, 4'h0, i + 3);
			`CHK(r, LPD_RESP_OKAY);
			rd(CH[i], i + 2);
			`CHK({r, d}, {LPD_RESP_OKAY, 32'hd5});
		end
		rd(12'h004);
		`CHK({r, d}, {LPD_RESP_SLVERR, 32'h0});
		wr(12'h004, 8'h11, 4'h1);
		`CHK(r, LPD_RESP_SLVERR);
		wr({LPD_IDX_STATUS, 2'b00}, 8'h11, 4'h1);
		`CHK(r, LPD_RESP_OKAY);
		// New codes must show in full from the first whole period after the writes.
		for (j = 0; j < 2; j++)
		begin
			for (i = 0; i < 3; i++)
				wr(CH[i], CODE[j][i], 4'h1);
			repeat (1900) @(posedge aclk);
			clr <= 1'b1;
			@(posedge aclk);
			clr <= 1'b0;
			repeat (1900) @(posedge aclk);
			#1;
			for (i = 0; i < 3; i++)
				`CHK(lit[i], 16'((CODE[j][i] > 95 ? 95 : CODE[j][i]) * 20));
			@(posedge aclk);
		end
		// Ramp from 1 to 6; one strobe every 3000 cycles bounds how fast it may get there.
		wr(CH[0], 8'h86, 4'h1);
		prv = 7'h1;
		for (k = 0; k < 80 && prv != 7'h6; k++)
		begin
			repeat (500) @(posedge aclk);
			rd({LPD_IDX_STATUS, 2'b00});
			cur = d[6:0];
			`CHK(cur == prv || cur == prv + 7'h1, 1'b1);
			prv = cur;
		end
		`CHK({prv, k >= 20}, {7'h6, 1'b1});
		`CHK(d[22:8], {7'h7f, 1'b0, 7'h5e});
		// Ramp back down to 4; two steps need two strobes, so it cannot finish in a few samples.
		wr(CH[0], 8'h84, 4'h1);
		for (k = 0; k < 80 && prv != 7'h4; k++)
		begin
			repeat (500) @(posedge aclk);
			rd({LPD_IDX_STATUS, 2'b00});
			cur = d[6:0];
			`CHK(cur == prv || cur + 7'h1 == prv, 1'b1);
			prv = cur;
		end
		`CHK({prv, k >= 3}, {7'h4, 1'b1});
		wrap_up;
	end
	initial
	begin
		repeat (80000) @(posedge aclk);
		error_cnt++;
		wrap_up;
	end
endmodule
